// ==== logic/cic_irq_ctrl.sv ====
// can interrupt flag, enable, priority and pin control block with apb slave
// Behaviour
// [RULE_01] drive-high select 1 drives tx pin high when recessive, else float
// [RULE_02] route bit 1 feeds can receive signal to capture unit, else pin
// [RULE_03] invalid message on bus sets flag bit 7
// [RULE_04] bus activity sets wake flag bit 6
// [RULE_05] any can error source sets error flag bit 5
// [RULE_06] mode 0: transmit buffer 2 done sets flag bit 4
// [RULE_07] modes 1,2: bit 4 set when any transmit buffer done
// [RULE_08] mode 0: transmit buffers 1 and 0 done set bits 3 and 2
// [RULE_09] modes 1,2: bits 3,2 of flags, enables, priorities read zero
// [RULE_10] mode 0: receive buffers 1 and 0 new message set bits 1, 0
// [RULE_11] modes 1,2: bit 1 set when any receive buffer got message
// [RULE_12] mode 2: bit 0 is fifo watermark flag; mode 1: bit 0 zero
// [RULE_13] invalid message interrupt only while enable bit 7 set
// [RULE_14] wake interrupt only while enable bit 6 set
// [RULE_15] error interrupt only while enable bit 5 set
// [RULE_16] modes 1,2: enable bit 4 zero blocks all transmit interrupts
// [RULE_17] modes 1,2: enable bit 1 zero blocks all receive interrupts
// [RULE_18] mode 2: watermark interrupt only while enable bit 0 set
// [RULE_19] priority 1 routes to high output, 0 to low; reset to ones
// [RULE_20] mode 2: priority bit 0 selects watermark interrupt priority
// [RULE_21] modes 1,2: transmit buffer needs own enable and group enable
// [RULE_22] flag and enable set raise chosen output until flag cleared
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cic_regs.svh"

module cic_irq_ctrl
  import cic_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // protocol engine events, one-cycle pulses
  input  wire logic        ev_invalid_msg,
  input  wire logic        ev_bus_wake,
  input  wire logic        ev_can_error,
  input  wire logic [2:0]  ev_tx_done,
  input  wire logic [1:0]  ev_rx_new,
  input  wire logic [5:0]  ev_prog_tx,
  input  wire logic [5:0]  ev_prog_rx,
  input  wire logic        ev_fifo_mark,
  // transmit pin
  input  wire logic        can_tx_dominant,
  output logic             can_tx_pin_out,
  output logic             can_tx_pin_oe,
  // capture routing
  input  wire logic        can_rx_msg,
  input  wire logic        capture_input_pin,
  output logic             capture_unit_in,
  // interrupt outputs
  output logic             irq_high,
  output logic             irq_low
);

  cic_state_t q;
  cic_state_t d;

  logic [7:0] mmask;
  logic [7:0] flags_eff;
  logic [7:0] en_eff;
  logic [7:0] pri_eff;
  logic [7:0] req;
  logic [7:0] set_v;
  logic [7:0] wr_flags;
  logic       acc;
  logic       wr;
  logic       rd_setup;
  logic       mapped;
  logic       tx_any;
  logic       rx_any;
  logic [31:0] rd_val;

  assign pready   = 1'b1;
  assign acc      = psel && penable;
  assign wr       = acc && pwrite && pstrb[0];
  assign rd_setup = psel && !penable && !pwrite;

  always_comb
  begin
    case (paddr)
      `CIC_OFF_PINCTL,
      `CIC_OFF_FLAGS,
      `CIC_OFF_ENABLES,
      `CIC_OFF_PRIOS,
      `CIC_OFF_MODE,
      `CIC_OFF_TX_BUFFER_ENABLE_REG,
      `CIC_OFF_BUFFER_ENABLE_REG,
      `CIC_OFF_STATUS:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  assign pslverr = acc && !mapped;

  // bits that exist in the current mode
  always_comb
  begin
    case (q.mode)
      CIC_MODE0:
        mmask = `CIC_MASK_MODE0;
      CIC_MODE1:
        mmask = `CIC_MASK_MODE1; // see [RULE_09] see [RULE_12]
      CIC_MODE2:
        mmask = `CIC_MASK_MODE2;
      default:
        mmask = `CIC_MASK_MODE2;
    endcase
  end

  assign flags_eff = q.flags & mmask; // see [RULE_09]
  assign en_eff    = q.en & mmask;
  assign pri_eff   = q.pri & mmask; // see [RULE_20]

  // individually enabled pending buffers, modes 1 and 2
  assign tx_any = |(q.tx_pend & q.tx_buffer_enable_reg) ||
                  |(q.ptx_pend & q.buffer_enable_reg[7:2]); // see [RULE_21]
  assign rx_any = |(q.rx_pend & q.buffer_enable_reg[1:0]) ||
                  |(q.prx_pend & q.buffer_enable_reg[7:2]);

  // requests: flag and enable, mode gated
  always_comb
  begin
    req = flags_eff & en_eff; // see [RULE_13] see [RULE_14] see [RULE_15]
    if (q.mode != CIC_MODE0)
    begin
      req[`CIC_B_TX2] = req[`CIC_B_TX2] && tx_any; // see [RULE_16]
      req[`CIC_B_RX1] = req[`CIC_B_RX1] && rx_any; // see [RULE_17]
    end
  end

  // hardware set events per mode
  always_comb
  begin
    set_v = `CIC_RST_ZERO8;
    set_v[`CIC_B_INVALID] = ev_invalid_msg; // see [RULE_03]
    set_v[`CIC_B_WAKE]    = ev_bus_wake; // see [RULE_04]
    set_v[`CIC_B_ERROR]   = ev_can_error; // see [RULE_05]
    if (q.mode == CIC_MODE0)
    begin
      set_v[`CIC_B_TX2] = ev_tx_done[2]; // see [RULE_06]
      set_v[`CIC_B_TX1] = ev_tx_done[1]; // see [RULE_08]
      set_v[`CIC_B_TX0] = ev_tx_done[0];
      set_v[`CIC_B_RX1] = ev_rx_new[1]; // see [RULE_10]
      set_v[`CIC_B_RX0] = ev_rx_new[0];
    end
    else
    begin
      set_v[`CIC_B_TX2] = |ev_tx_done || |ev_prog_tx; // see [RULE_07]
      set_v[`CIC_B_RX1] = |ev_rx_new || |ev_prog_rx; // see [RULE_11]
      set_v[`CIC_B_RX0] = (q.mode == CIC_MODE2) && ev_fifo_mark; // see [RULE_12]
    end
  end

  // read mux
  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (paddr)
      `CIC_OFF_PINCTL:
        rd_val[7:0] = {2'h0, q.pin, 4'h0};
      `CIC_OFF_FLAGS:
        rd_val[7:0] = flags_eff;
      `CIC_OFF_ENABLES:
        rd_val[7:0] = en_eff;
      `CIC_OFF_PRIOS:
        rd_val[7:0] = pri_eff;
      `CIC_OFF_MODE:
        rd_val[1:0] = q.mode;
      `CIC_OFF_TX_BUFFER_ENABLE_REG:
        rd_val[4:2] = q.tx_buffer_enable_reg;
      `CIC_OFF_BUFFER_ENABLE_REG:
        rd_val[7:0] = q.buffer_enable_reg;
      `CIC_OFF_STATUS:
        rd_val[1:0] = {q.irq_lo, q.irq_hi};
      default:
        rd_val = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    d = q;
    wr_flags = q.flags;
    if (wr)
    begin
      case (paddr)
        `CIC_OFF_PINCTL:
        begin
          d.pin[1] = pwdata[`CIC_PIN_DRVHI];
          d.pin[0] = pwdata[`CIC_PIN_ROUTE];
        end
        `CIC_OFF_FLAGS:
          wr_flags = pwdata[7:0] & mmask;
        `CIC_OFF_ENABLES:
          d.en = pwdata[7:0] & mmask;
        `CIC_OFF_PRIOS:
          d.pri = pwdata[7:0];
        `CIC_OFF_MODE:
        begin
          if (pwdata[1:0] == 2'h0)
            d.mode = CIC_MODE0;
          else if (pwdata[1:0] == 2'h1)
            d.mode = CIC_MODE1;
          else
            d.mode = CIC_MODE2;
        end
        `CIC_OFF_TX_BUFFER_ENABLE_REG:
          d.tx_buffer_enable_reg = pwdata[4:2];
        `CIC_OFF_BUFFER_ENABLE_REG:
          d.buffer_enable_reg = pwdata[7:0];
        default:
          d.pin = q.pin;
      endcase
    end
    // hardware set beats a software clear in the same cycle
    d.flags = wr_flags | (set_v & mmask); // see [RULE_22]

    // per-buffer pending, dropped when group flag is cleared
    d.tx_pend  = q.tx_pend | ev_tx_done;
    d.rx_pend  = q.rx_pend | ev_rx_new;
    d.ptx_pend = q.ptx_pend | ev_prog_tx;
    d.prx_pend = q.prx_pend | ev_prog_rx;
    if (!d.flags[`CIC_B_TX2])
    begin
      d.tx_pend  = 3'h0;
      d.ptx_pend = 6'h00;
    end
    if (!d.flags[`CIC_B_RX1])
    begin
      d.rx_pend  = 2'h0;
      d.prx_pend = 6'h00;
    end

    if (rd_setup)
      d.prdata = rd_val;

    d.irq_hi = |(req & pri_eff); // see [RULE_19] see [RULE_22]
    d.irq_lo = |(req & ~pri_eff); // see [RULE_19] see [RULE_18]

    // recessive: drive high or float
    d.tx_out = !can_tx_dominant;
    d.tx_oe  = can_tx_dominant || q.pin[1]; // see [RULE_01]
    d.cap_out = q.pin[0] ? can_rx_msg : capture_input_pin; // see [RULE_02]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q          <= '0;
      q.flags    <= `CIC_RST_FLAGS;
      q.en       <= `CIC_RST_ENABLES;
      q.pri      <= `CIC_RST_PRIOS; // see [RULE_19]
      q.mode     <= CIC_MODE0;
      q.tx_out   <= 1'b1;
    end
    else
      q <= d;
  end

  assign prdata          = q.prdata;
  assign can_tx_pin_out  = q.tx_out;
  assign can_tx_pin_oe   = q.tx_oe;
  assign capture_unit_in = q.cap_out;
  assign irq_high        = q.irq_hi;
  assign irq_low         = q.irq_lo;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_tx_recessive : // see [RULE_01]
  assert property (!can_tx_dominant && q.pin[1] |=> can_tx_pin_oe && can_tx_pin_out)
    else $error("recessive tx not driven high");

  chk_tx_float : // see [RULE_01]
  assert property (!can_tx_dominant && !q.pin[1] |=> !can_tx_pin_oe)
    else $error("recessive tx not floating");

  chk_cap_route : // see [RULE_02]
  assert property (q.pin[0] |=> capture_unit_in == $past(can_rx_msg))
    else $error("capture not fed by receive signal");

  chk_invalid_set : // see [RULE_03]
  assert property (ev_invalid_msg |=> q.flags[`CIC_B_INVALID])
    else $error("invalid message flag not set");

  chk_tx2_mode0 : // see [RULE_06]
  assert property (q.mode == CIC_MODE0 && ev_tx_done[2] |=> q.flags[`CIC_B_TX2])
    else $error("tx2 done flag not set");

  chk_forced_zero : // see [RULE_09]
  assert property (q.mode != CIC_MODE0 && rd_setup && paddr == `CIC_OFF_FLAGS
                   |=> prdata[3:2] == 2'h0)
    else $error("forced-zero flag bits read nonzero");

  chk_tx_group : // see [RULE_16]
  assert property (q.mode != CIC_MODE0 && !q.en[`CIC_B_TX2] |-> !req[`CIC_B_TX2])
    else $error("tx interrupt passed with group enable clear");

  chk_high_route : // see [RULE_19]
  assert property (q.flags[`CIC_B_INVALID] && q.en[`CIC_B_INVALID]
                   && q.pri[`CIC_B_INVALID] |=> irq_high)
    else $error("high priority request not raised");

  chk_low_route : // see [RULE_19]
  assert property (req != 8'h00 && (req & pri_eff) == 8'h00
                   |=> !irq_high && irq_low)
    else $error("low priority request misrouted");

  chk_flag_holds : // see [RULE_22]
  assert property (q.flags[`CIC_B_ERROR] && !(wr && paddr == `CIC_OFF_FLAGS)
                   |=> q.flags[`CIC_B_ERROR])
    else $error("error flag lost without a clear");

  chk_wake_set : // see [RULE_04]
  assert property (ev_bus_wake |=> q.flags[`CIC_B_WAKE])
    else $error("bus wake flag not set");

  chk_error_set : // see [RULE_05]
  assert property (ev_can_error |=> q.flags[`CIC_B_ERROR])
    else $error("can error flag not set");

  chk_any_tx_set : // see [RULE_07]
  assert property (q.mode != CIC_MODE0 && (|ev_tx_done || |ev_prog_tx)
                   |=> q.flags[`CIC_B_TX2])
    else $error("any transmit done flag not set");

  chk_any_rx_set : // see [RULE_11]
  assert property (q.mode != CIC_MODE0 && (|ev_rx_new || |ev_prog_rx)
                   |=> q.flags[`CIC_B_RX1])
    else $error("any receive new flag not set");

  chk_fifo_set : // see [RULE_12]
  assert property (q.mode == CIC_MODE2 && ev_fifo_mark |=> q.flags[`CIC_B_RX0])
    else $error("fifo watermark flag not set");

  chk_mode1_bit0 : // see [RULE_12]
  assert property (q.mode == CIC_MODE1 && rd_setup && paddr == `CIC_OFF_FLAGS
                   |=> prdata[`CIC_B_RX0] == 1'b0)
    else $error("mode 1 flag bit 0 reads nonzero");

  chk_rx_group : // see [RULE_17]
  assert property (q.mode != CIC_MODE0 && !q.en[`CIC_B_RX1] |-> !req[`CIC_B_RX1])
    else $error("rx interrupt passed with group enable clear");

  chk_no_request : // see [RULE_22]
  assert property (req == 8'h00 |=> !irq_high && !irq_low)
    else $error("interrupt raised without a request");

  chk_pin_route : // see [RULE_02]
  assert property (!q.pin[0] |=> capture_unit_in == $past(capture_input_pin))
    else $error("capture not fed by capture pin");

  chk_tx_dominant : // see [RULE_01]
  assert property (can_tx_dominant |=> can_tx_pin_oe && !can_tx_pin_out)
    else $error("dominant tx not driven low");

  cov_high_irq : cover property ($rose(irq_high));
  cov_low_irq  : cover property ($rose(irq_low));
  cov_fifo     : cover property (q.mode == CIC_MODE2 && ev_fifo_mark ##1 q.flags[`CIC_B_RX0]);
  cov_set_clr  : cover property (wr && paddr == `CIC_OFF_FLAGS && ev_can_error);
  cov_any_tx   : cover property (q.mode != CIC_MODE0 && req[`CIC_B_TX2]);

endmodule // cic_irq_ctrl
`default_nettype wire

// ==== logic/cic_pkg.sv ====
// types of the can irq and pin control block
`default_nettype none
package cic_pkg;

  typedef enum logic [1:0] {
    CIC_MODE0,
    CIC_MODE1,
    CIC_MODE2
  } cic_mode_t;

  typedef struct packed {
    logic [1:0]  pin;
    logic [7:0]  flags;
    logic [7:0]  en;
    logic [7:0]  pri;
    cic_mode_t   mode;
    logic [2:0]  tx_buffer_enable_reg;
    logic [7:0]  buffer_enable_reg;
    logic [2:0]  tx_pend;
    logic [1:0]  rx_pend;
    logic [5:0]  ptx_pend;
    logic [5:0]  prx_pend;
    logic [31:0] prdata;
    logic        irq_hi;
    logic        irq_lo;
    logic        tx_out;
    logic        tx_oe;
    logic        cap_out;
  } cic_state_t;

endpackage
`default_nettype wire

// ==== logic/cic_regs.svh ====
// register offsets, field positions and reset values of the can irq block
`ifndef CIC_REGS_SVH
`define CIC_REGS_SVH

`define CIC_OFF_PINCTL   12'h000
`define CIC_OFF_FLAGS    12'h004
`define CIC_OFF_ENABLES  12'h008
`define CIC_OFF_PRIOS    12'h00c
`define CIC_OFF_MODE     12'h010
`define CIC_OFF_TX_BUFFER_ENABLE_REG    12'h014
`define CIC_OFF_BUFFER_ENABLE_REG     12'h018
`define CIC_OFF_STATUS   12'h01c

`define CIC_PIN_DRVHI    5
`define CIC_PIN_ROUTE    4

`define CIC_B_INVALID    7
`define CIC_B_WAKE       6
`define CIC_B_ERROR      5
`define CIC_B_TX2        4
`define CIC_B_TX1        3
`define CIC_B_TX0        2
`define CIC_B_RX1        1
`define CIC_B_RX0        0

`define CIC_MASK_MODE0   8'hff
`define CIC_MASK_MODE1   8'hf2
`define CIC_MASK_MODE2   8'hf3
`define CIC_MASK_TXRX    8'h12

`define CIC_RST_FLAGS    8'h00
`define CIC_RST_ENABLES  8'h00
`define CIC_RST_PRIOS    8'hff
`define CIC_RST_ZERO8    8'h00

`define CIC_ADDR_LSB     2
`define CIC_ADDR_MSB     11

`endif

// ==== verif/cic_engine_model.sv ====
// event source model of the can protocol engine
`timescale 1ns/1ps
`default_nettype none
module cic_engine_model (
  // clock
  input  wire logic        pclk,
  // event request from bench
  input  wire logic [20:0] req,
  // event pulses, one cycle each
  output logic [5:0]       ev_prog_tx,
  output logic [5:0]       ev_prog_rx,
  output logic             ev_invalid_msg,
  output logic             ev_bus_wake,
  output logic             ev_can_error,
  output logic [2:0]       ev_tx_done,
  output logic [1:0]       ev_rx_new,
  output logic             ev_fifo_mark
);
  // one register stage between bench request and event pulses
  always @(posedge pclk)
  begin
    {ev_prog_tx, ev_prog_rx, ev_invalid_msg, ev_bus_wake, ev_can_error, ev_tx_done,
     ev_rx_new, ev_fifo_mark} <= req;
  end
endmodule // cic_engine_model
`default_nettype wire

// ==== verif/cic_irq_ctrl_tb.sv ====
// self-checking testbench of the can irq and pin control block
`timescale 1ns/1ps
`default_nettype none
`include "cic_regs.svh"
`define CMP(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); fail_count++; end end
module cic_irq_ctrl_tb;
  typedef struct packed {
    logic [1:0]  m;
    logic [7:0]  en;
    logic [7:0]  pri;
    logic [20:0] ev;
    logic [7:0]  fl;
    logic        hi;
    logic        lo;
  } cic_row_t;
  logic        pclk;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic        can_tx_dominant = 1'h0;
  logic        can_rx_msg = 1'h0;
  logic        capture_input_pin = 1'h0;
  logic [20:0] req = 21'h0;
  logic [31:0] rd;
  logic        err;
  int          fail_count = 0;
  int          tests_run = 0;
  wire         pready, pslverr, ev_invalid_msg, ev_bus_wake, ev_can_error, ev_fifo_mark;
  wire         can_tx_pin_out, can_tx_pin_oe, capture_unit_in, irq_high, irq_low;
  wire [31:0]  prdata;
  wire [5:0]   ev_prog_tx, ev_prog_rx;
  wire [2:0]   ev_tx_done;
  wire [1:0]   ev_rx_new;
  cic_row_t    r;
  localparam cic_row_t ROWS [16] = '{
    '{2'h0, 8'h80, 8'hff, 21'h100, 8'h80, 1'h1, 1'h0},
    '{2'h0, 8'h00, 8'hff, 21'h100, 8'h80, 1'h0, 1'h0},
    '{2'h0, 8'h40, 8'hbf, 21'h080, 8'h40, 1'h0, 1'h1},
    '{2'h0, 8'h20, 8'hff, 21'h040, 8'h20, 1'h1, 1'h0},
    '{2'h0, 8'h10, 8'hff, 21'h020, 8'h10, 1'h1, 1'h0},
    '{2'h0, 8'h0c, 8'hf3, 21'h018, 8'h0c, 1'h0, 1'h1},
    '{2'h0, 8'h03, 8'hff, 21'h006, 8'h03, 1'h1, 1'h0},
    '{2'h1, 8'h12, 8'hff, 21'h008, 8'h10, 1'h1, 1'h0},
    '{2'h1, 8'h02, 8'hff, 21'h020, 8'h10, 1'h0, 1'h0},
    '{2'h1, 8'h12, 8'hff, 21'h002, 8'h02, 1'h1, 1'h0},
    '{2'h1, 8'h10, 8'hff, 21'h004, 8'h02, 1'h0, 1'h0},
    '{2'h1, 8'hff, 8'hff, 21'h001, 8'h00, 1'h0, 1'h0},
    '{2'h1, 8'h02, 8'hff, 21'h200, 8'h02, 1'h1, 1'h0},
    '{2'h2, 8'h01, 8'hfe, 21'h001, 8'h01, 1'h0, 1'h1},
    '{2'h2, 8'h00, 8'hff, 21'h001, 8'h01, 1'h0, 1'h0},
    '{2'h2, 8'h10, 8'hef, 21'h100000, 8'h10, 1'h0, 1'h1}
  };
  cic_irq_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .ev_invalid_msg, .ev_bus_wake, .ev_can_error, .ev_tx_done,
    .ev_rx_new, .ev_prog_tx, .ev_prog_rx, .ev_fifo_mark, .can_tx_dominant, .can_tx_pin_out,
    .can_tx_pin_oe, .can_rx_msg, .capture_input_pin, .capture_unit_in, .irq_high, .irq_low);
  cic_engine_model u_eng (.pclk, .req, .ev_prog_tx, .ev_prog_rx, .ev_invalid_msg,
    .ev_bus_wake, .ev_can_error, .ev_tx_done, .ev_rx_new, .ev_fifo_mark);
  task automatic print_verdict();
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e, input string n);
    apb(1'h0, a, 32'h0);
    `CMP(n, {24'h0, e}, rd)
  endtask
  task automatic fire(input logic [20:0] v);
    req <= v;
    @(posedge pclk);
    req <= 21'h0;
    repeat (3) @(posedge pclk);
  endtask
  function automatic logic [7:0] mask(input logic [1:0] m);
    return (m == 2'h0) ? 8'hff : (m == 2'h1) ? 8'hf2 : 8'hf3;
  endfunction
  initial
  begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  initial
  begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    print_verdict();
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rdchk(`CIC_OFF_PRIOS, 8'hff, "prios");
    rdchk(`CIC_OFF_FLAGS, 8'h00, "flags");
    rdchk(`CIC_OFF_ENABLES, 8'h00, "enables");
    apb(1'h1, `CIC_OFF_TX_BUFFER_ENABLE_REG, 32'h1c);
    apb(1'h1, `CIC_OFF_BUFFER_ENABLE_REG, 32'hff);
    foreach (ROWS[i])
    begin
      r = ROWS[i];
      apb(1'h1, `CIC_OFF_MODE, {30'h0, r.m});
      apb(1'h1, `CIC_OFF_ENABLES, {24'h0, r.en});
      apb(1'h1, `CIC_OFF_PRIOS, {24'h0, r.pri});
      apb(1'h1, `CIC_OFF_FLAGS, 32'h0);
      fire(r.ev);
      `CMP("irq_high", r.hi, irq_high)
      `CMP("irq_low", r.lo, irq_low)
      rdchk(`CIC_OFF_FLAGS, r.fl, "flags");
      rdchk(`CIC_OFF_ENABLES, r.en & mask(r.m), "enables");
    end
    can_rx_msg <= 1'h1;
    apb(1'h1, `CIC_OFF_PINCTL, 32'hff);
    rdchk(`CIC_OFF_PINCTL, 8'h30, "pinctl");
    `CMP("tx_oe", 1'h1, can_tx_pin_oe)
    `CMP("tx_out", 1'h1, can_tx_pin_out)
    `CMP("capture", 1'h1, capture_unit_in)
    can_rx_msg <= 1'h0;
    capture_input_pin <= 1'h1;
    apb(1'h1, `CIC_OFF_PINCTL, 32'h0);
    @(posedge pclk);
    `CMP("tx_oe", 1'h0, can_tx_pin_oe)
    `CMP("capture", 1'h1, capture_unit_in)
    can_tx_dominant <= 1'h1;
    repeat (2) @(posedge pclk);
    `CMP("tx_oe_dom", 1'h1, can_tx_pin_oe)
    `CMP("tx_out_dom", 1'h0, can_tx_pin_out)
    can_tx_dominant <= 1'h0;
    apb(1'h0, 12'h0f0, 32'h0);
    `CMP("slverr", 1'h1, err)
    `CMP("unmapped", 32'h0, rd)
    apb(1'h1, `CIC_OFF_MODE, 32'h3);
    rdchk(`CIC_OFF_MODE, 8'h02, "mode3");
    apb(1'h1, `CIC_OFF_MODE, 32'h0);
    apb(1'h1, `CIC_OFF_ENABLES, 32'h20);
    apb(1'h1, `CIC_OFF_PRIOS, 32'h0);
    fire(21'h040);
    `CMP("irq_low", 1'h1, irq_low)
    rdchk(`CIC_OFF_STATUS, 8'h02, "status");
    pstrb <= 4'h0;
    apb(1'h1, `CIC_OFF_FLAGS, 32'h0);
    pstrb <= 4'hf;
    @(posedge pclk);
    `CMP("strb_refused", 1'h1, irq_low)
    apb(1'h1, `CIC_OFF_FLAGS, 32'h0);
    @(posedge pclk);
    `CMP("irq_low", 1'h0, irq_low)
    fire(21'h040);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    `CMP("rst_irq_low", 1'h0, irq_low)
    `CMP("rst_tx_oe", 1'h0, can_tx_pin_oe)
    `CMP("rst_tx_out", 1'h1, can_tx_pin_out)
    `CMP("rst_capture", 1'h0, capture_unit_in)
    presetn <= 1'h1;
    @(posedge pclk);
    rdchk(`CIC_OFF_PRIOS, 8'hff, "rst_prios");
    rdchk(`CIC_OFF_FLAGS, 8'h00, "rst_flags");
    print_verdict();
  end
endmodule // cic_irq_ctrl_tb
`default_nettype wire
